// ---- rtl/sleep_rail_defs.svh ----
`ifndef SLEEP_RAIL_DEFS_SVH
`define SLEEP_RAIL_DEFS_SVH

// Register offsets
`define SRC_ADDR_OFF_LOW 8'h29
`define SRC_ADDR_OFF_MISC 8'h2a
`define SRC_ADDR_VSEL 8'h2b

// Value held between power-on reset and the default load
`define SRC_REG_RST 8'h00
`define SRC_RDATA_NONE 8'h00

// Field positions in sleep_off_converters_misc
`define SRC_THERM_BIT 7
`define SRC_CLK32_BIT 6
`define SRC_MISC_RAIL_MSB 5

// Rail counts; rails 0..7 regulators 1..8, 8..9 regulators 9..10,
// 10..13 converters 1..4
`define SRC_RAILS 14
`define SRC_MAPPED 4
`define SRC_CONV 4
// Regulator k voltage-select bit sits at this base plus k
`define SRC_VSEL_REG_BASE 4

`endif

// ---- rtl/sleep_rail_pkg.sv ----
package sleep_rail_pkg;
  `include "sleep_rail_defs.svh"

  typedef enum logic [2:0] {
    RAIL_ACTIVE = 3'b001,
    RAIL_ECO = 3'b010,
    RAIL_OFF = 3'b100
  } rail_mode_t;

  typedef rail_mode_t [`SRC_RAILS-1:0] rail_mode_vec_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] off_low;
    logic [7:0] off_misc;
    logic [7:0] vsel;
  } otp_defaults_t;

  typedef struct packed {
    logic [1:0] map;
    logic en;
  } pin_map_t;
endpackage

// ---- rtl/rail_sleep_decode.sv ----
`timescale 1ns/100ps
module rail_sleep_decode
  import sleep_rail_pkg::*;
(
  input wire logic [`SRC_RAILS-1:0] i_keep_on, // Keep-on per rail
  input wire logic [`SRC_RAILS-1:0] i_set_off, // Set-off per rail
  output wire rail_mode_vec_t o_mode // Sleep mode per rail
);

  function automatic rail_mode_t sleep_mode(input logic keep, input logic off);
    if (keep) begin
      return RAIL_ACTIVE;
    end else if (off) begin
      return RAIL_OFF;
    end
    return RAIL_ECO;
  endfunction

  genvar g;
  generate
    for (g = 0; g < `SRC_RAILS; g++) begin : g_rail
      assign o_mode[g] = sleep_mode(i_keep_on[g], i_set_off[g]);
    end
  endgenerate
endmodule

// ---- rtl/sleep_rail_state_control.sv ----
`timescale 1ns/100ps
// What this block does
// - Two set-off registers: regulators 1-8, then converters, regulators 10,9.
// - Set-off one with keep-on zero turns the rail off in sleep.
// - Bit 7 thermal monitor, bit 6 slow clock out: one means off in sleep.
// - Voltage-select register; zero bit uses operating voltage register.
// - Voltage-select one uses the scaling voltage register.
// - Sleep: eco if both zero, active if keep-on, off if set-off only.
// - Voltage-select choice is independent of sleep state.
// - Power-on reset reloads defaults; all bits stay host read/write, except voltage-select bits driven by an enabled pin map.
// - Keep-on zero gives eco in sleep unless set-off is one, one keeps rail active.
// - Regulators 1-4 may follow a mapped converter select pin.
module sleep_rail_state_control
  import sleep_rail_pkg::*;
(
  input wire logic i_sys_clk, // 250 MHz clock
  input wire logic i_reset_n, // Async power-on reset, low
  input wire logic i_clk_en, // Freezes all state when low
  input reg_req_t i_req, // Register access from serial port
  input otp_defaults_t i_otp, // One-time-programmed defaults
  input wire logic [`SRC_RAILS-1:0] i_keep_on, // Keep-on bits per rail
  input pin_map_t [`SRC_MAPPED-1:0] i_pin_map, // Pin mapping, regs 1-4
  input wire logic [`SRC_CONV-1:0] i_conv_sel_pin, // Converter select pins
  input wire logic i_sleep, // Sleep request pin
  output logic [7:0] o_rdata, // Read data
  output logic o_rvalid, // Read data valid pulse
  output rail_mode_vec_t o_rail_mode, // Applied mode per rail
  output logic [7:0] o_use_scaling, // Voltage register choice
  output logic o_therm_en, // Thermal monitor enable
  output logic o_slow_clk_en // Slow clock output enable
);

  logic [7:0] off_low_r;
  logic [7:0] off_misc_r;
  logic [7:0] vsel_r;
  logic [7:0] vsel_nxt;
  logic load_pend_r;
  logic sleep_meta_r;
  logic sleep_sync_r;
  logic [`SRC_CONV-1:0] pin_meta_r;
  logic [`SRC_CONV-1:0] pin_sync_r;
  logic [`SRC_RAILS-1:0] set_off_vec;
  rail_mode_vec_t sleep_mode;
  logic host_ok;

  function automatic logic hit(input reg_req_t req, input logic [7:0] addr);
    return req.addr == addr;
  endfunction

  // Host access is refused until the defaults are in place
  assign host_ok = i_clk_en && !load_pend_r;

  // Defaults are caught on the first enabled edge after reset release;
  // the async reset itself may only load constants.
  // Default reload
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      load_pend_r <= 1'b1;
    end else if (i_clk_en) begin
      load_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      off_low_r <= `SRC_REG_RST;
      off_misc_r <= `SRC_REG_RST;
    end else if (i_clk_en) begin
      if (load_pend_r) begin
        off_low_r <= i_otp.off_low;
        off_misc_r <= i_otp.off_misc;
      end else if (i_req.wr) begin
        if (hit(i_req, `SRC_ADDR_OFF_LOW)) begin
          off_low_r <= i_req.wdata;
        end
        if (hit(i_req, `SRC_ADDR_OFF_MISC)) begin
          off_misc_r <= i_req.wdata;
        end
      end
    end
  end

  // Pin inputs come from outside the clock domain
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sleep_meta_r <= 1'b0;
      sleep_sync_r <= 1'b0;
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else if (i_clk_en) begin
      sleep_meta_r <= i_sleep;
      sleep_sync_r <= sleep_meta_r;
      pin_meta_r <= i_conv_sel_pin;
      pin_sync_r <= pin_meta_r;
    end
  end

  // A mapped pin wins over a host write in the same cycle
  always_comb begin
    vsel_nxt = vsel_r;
    if (host_ok && i_req.wr && hit(i_req, `SRC_ADDR_VSEL)) begin
      vsel_nxt = i_req.wdata;
    end
    for (int k = 0; k < `SRC_MAPPED; k++) begin
      if (i_pin_map[k].en) begin
        vsel_nxt[`SRC_VSEL_REG_BASE + k] = pin_sync_r[i_pin_map[k].map];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      vsel_r <= `SRC_REG_RST;
    end else if (i_clk_en) begin
      if (load_pend_r) begin
        vsel_r <= i_otp.vsel;
      end else begin
        vsel_r <= vsel_nxt;
      end
    end
  end

  // One bit picks the scaling register, independent of sleep
  assign o_use_scaling = vsel_r;

  // Rail order: regulators 1..8, 9, 10, converters 1..4
  assign set_off_vec = {off_misc_r[`SRC_MISC_RAIL_MSB:0], off_low_r};

  rail_sleep_decode u_decode (
    .i_keep_on(i_keep_on),
    .i_set_off(set_off_vec),
    .o_mode(sleep_mode)
  );

  // Apply sleep modes only while asleep
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int k = 0; k < `SRC_RAILS; k++) begin
        o_rail_mode[k] <= RAIL_ACTIVE;
      end
    end else if (i_clk_en) begin
      for (int k = 0; k < `SRC_RAILS; k++) begin
        o_rail_mode[k] <= sleep_sync_r ? sleep_mode[k] : RAIL_ACTIVE;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_therm_en <= 1'b1;
      o_slow_clk_en <= 1'b1;
    end else if (i_clk_en) begin
      o_therm_en <= !(sleep_sync_r && off_misc_r[`SRC_THERM_BIT]);
      o_slow_clk_en <= !(sleep_sync_r && off_misc_r[`SRC_CLK32_BIT]);
    end
  end

  // Unmapped offsets read as zero
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= `SRC_RDATA_NONE;
      o_rvalid <= 1'b0;
    end else if (i_clk_en) begin
      o_rvalid <= host_ok && i_req.rd;
      if (host_ok && i_req.rd) begin
        if (hit(i_req, `SRC_ADDR_OFF_LOW)) begin
          o_rdata <= off_low_r;
        end else if (hit(i_req, `SRC_ADDR_OFF_MISC)) begin
          o_rdata <= off_misc_r;
        end else if (hit(i_req, `SRC_ADDR_VSEL)) begin
          o_rdata <= vsel_r;
        end else begin
          o_rdata <= `SRC_RDATA_NONE;
        end
      end
    end
  end

  // Assertions
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  otp_load_a: assert property (
    load_pend_r && i_clk_en |=> off_low_r == $past(i_otp.off_low)
      && off_misc_r == $past(i_otp.off_misc))
    else $error("Set-off defaults not loaded");

  host_write_a: assert property (
    host_ok && i_req.wr && hit(i_req, `SRC_ADDR_OFF_LOW)
      |=> off_low_r == $past(i_req.wdata))
    else $error("Set-off write lost");

  rail_off_a: assert property (
    i_clk_en && sleep_sync_r && set_off_vec[0] && !i_keep_on[0]
      |=> o_rail_mode[0] == RAIL_OFF)
    else $error("Rail not switched off in sleep");

  keep_active_a: assert property (
    i_clk_en && sleep_sync_r && i_keep_on[13]
      |=> o_rail_mode[13] == RAIL_ACTIVE)
    else $error("Kept rail not active");

  eco_mode_a: assert property (
    i_clk_en && sleep_sync_r && !i_keep_on[8] && !set_off_vec[8]
      |=> o_rail_mode[8] == RAIL_ECO)
    else $error("Rail not in eco mode");

  wake_active_a: assert property (
    i_clk_en && !sleep_sync_r |=> o_rail_mode == {`SRC_RAILS{RAIL_ACTIVE}})
    else $error("Rail not active outside sleep");

  therm_off_a: assert property (
    i_clk_en && sleep_sync_r |=>
      o_therm_en == !$past(off_misc_r[`SRC_THERM_BIT])
      && o_slow_clk_en == !$past(off_misc_r[`SRC_CLK32_BIT]))
    else $error("Sleep enable bits not applied");

  vsel_write_a: assert property (
    host_ok && i_req.wr && hit(i_req, `SRC_ADDR_VSEL) && !i_pin_map[0].en
      |=> o_use_scaling[`SRC_VSEL_REG_BASE]
        == $past(i_req.wdata[`SRC_VSEL_REG_BASE]))
    else $error("Voltage select write lost");

  pin_follow_a: assert property (
    i_clk_en && !load_pend_r && i_pin_map[1].en
      |=> o_use_scaling[`SRC_VSEL_REG_BASE + 1]
        == $past(pin_sync_r[i_pin_map[1].map]))
    else $error("Mapped pin not followed");

  vsel_stable_a: assert property (
    i_clk_en && !load_pend_r && !(i_req.wr && hit(i_req, `SRC_ADDR_VSEL))
      && i_pin_map[0].en == 1'b0 && i_pin_map[1].en == 1'b0
      && i_pin_map[2].en == 1'b0 && i_pin_map[3].en == 1'b0
      |=> $stable(o_use_scaling))
    else $error("Voltage choice moved with sleep");
endmodule

// ---- sim/host_model.sv ----
`timescale 1ns/100ps
module host_model
  import sleep_rail_pkg::*;
(
  input wire logic i_sys_clk, // Device clock
  input wire logic [7:0] i_rdata, // Read data
  input wire logic i_rvalid, // Read data valid
  output reg_req_t o_req // Register request
);
  initial o_req = '0;

  // One-cycle strobe; data is inverted after release so stale data never
  // looks valid
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_sys_clk);
    o_req.wr <= 1'b0;
    o_req.wdata <= ~d;
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d,
                        output logic ok);
    int n;
    @(posedge i_sys_clk);
    o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_sys_clk);
    o_req.rd <= 1'b0;
    ok = 1'b0;
    for (n = 0; n < 4 && !ok; n++) begin
      #1;
      if (i_rvalid === 1'b1) ok = 1'b1;
      else @(posedge i_sys_clk);
    end
    d = i_rdata;
  endtask
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/100ps
module tb;
  import sleep_rail_pkg::*;
  logic i_sys_clk, i_reset_n, i_sleep, rvalid, therm_en, slow_clk_en;
  reg_req_t req;
  otp_defaults_t otp;
  logic [`SRC_RAILS-1:0] keep_on;
  pin_map_t [`SRC_MAPPED-1:0] pin_map;
  logic [`SRC_CONV-1:0] conv_pin;
  logic [7:0] rdata, use_scaling;
  rail_mode_vec_t rail_mode;
  int err_count, samples_checked;
  logic clk_en;
  logic [7:0] pat [3] = '{8'hff, 8'h00, 8'ha5};

  sleep_rail_state_control dut (.i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n), .i_clk_en(clk_en), .i_req(req), .i_otp(otp),
    .i_keep_on(keep_on), .i_pin_map(pin_map), .i_conv_sel_pin(conv_pin),
    .i_sleep(i_sleep), .o_rdata(rdata), .o_rvalid(rvalid),
    .o_rail_mode(rail_mode), .o_use_scaling(use_scaling),
    .o_therm_en(therm_en), .o_slow_clk_en(slow_clk_en));
  host_model host (.i_sys_clk(i_sys_clk), .i_rdata(rdata),
    .i_rvalid(rvalid), .o_req(req));

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // A read that never answers ends the run
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host.reg_rd(a, d, ok);
    if (ok !== 1'b1) begin
      err_count++;
      end_sim();
    end else chk(d, e);
  endtask

  function automatic rail_mode_vec_t exp_modes(logic [13:0] k,
                                               logic [13:0] s, logic slp);
    for (int i = 0; i < `SRC_RAILS; i++)
      exp_modes[i] = (!slp || k[i]) ? RAIL_ACTIVE :
                     (s[i] ? RAIL_OFF : RAIL_ECO);
  endfunction

  task automatic chk_out(input logic [7:0] lo, misc, input logic slp);
    chk(rail_mode, exp_modes(keep_on, {misc[5:0], lo}, slp));
    chk(therm_en, !(slp && misc[7]));
    chk(slow_clk_en, !(slp && misc[6]));
  endtask

  initial begin
    i_sys_clk = 1'b0;
    forever #2 i_sys_clk = ~i_sys_clk;
  end

  initial begin
    i_reset_n = 1'b0;
    i_sleep = 1'b0;
    clk_en = 1'b1;
    keep_on = '0;
    pin_map = '0;
    conv_pin = '0;
    otp = '{off_low: 8'h19, off_misc: 8'h84, vsel: 8'h5a};
    err_count = 0;
    samples_checked = 0;
    @(posedge i_sys_clk);
    #1 chk(rail_mode, exp_modes(keep_on, '0, 1'b0));
    chk(use_scaling, 8'h00);
    @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    @(posedge i_sys_clk);
    rd_chk(8'h29, 8'h19);
    rd_chk(8'h2a, 8'h84);
    rd_chk(8'h2b, 8'h5a);
    $display("test defaults done");
    for (int a = 8'h29; a <= 8'h2b; a++) begin
      foreach (pat[p]) begin
        host.reg_wr(a[7:0], pat[p]);
        rd_chk(a[7:0], pat[p]);
      end
    end
    host.reg_wr(8'h2c, 8'h77);
    rd_chk(8'h2c, 8'h00);
    $display("test access done");
    // Overlap of keep-on and set-off covers the keep-on-wins case
    host.reg_wr(8'h29, 8'h3c);
    host.reg_wr(8'h2a, 8'h9a);
    host.reg_wr(8'h2b, 8'hc3);
    @(posedge i_sys_clk);
    keep_on <= 14'h2a5c;
    i_sleep <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    #1 chk_out(8'h3c, 8'h9a, 1'b1);
    chk(use_scaling, 8'hc3);
    host.reg_wr(8'h2a, 8'h65);
    repeat (2) @(posedge i_sys_clk);
    #1 chk_out(8'h3c, 8'h65, 1'b1);
    @(posedge i_sys_clk);
    i_sleep <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    #1 chk_out(8'h3c, 8'h65, 1'b0);
    chk(use_scaling, 8'hc3);
    $display("test sleep done");
    @(posedge i_sys_clk);
    pin_map[1] <= '{map: 2'd2, en: 1'b1};
    conv_pin <= 4'b0100;
    repeat (4) @(posedge i_sys_clk);
    #1 chk(use_scaling, 8'he3);
    @(posedge i_sys_clk);
    conv_pin <= 4'b1011;
    repeat (4) @(posedge i_sys_clk);
    #1 chk(use_scaling, 8'hc3);
    $display("test pin map done");
    // A write while the clock enable is low must not land
    @(posedge i_sys_clk);
    clk_en <= 1'b0;
    host.reg_wr(8'h29, 8'h5a);
    @(posedge i_sys_clk);
    clk_en <= 1'b1;
    rd_chk(8'h29, 8'h3c);
    $display("test clock enable done");
    // Second power-on reset reloads a different default set
    i_reset_n <= 1'b0;
    otp <= '{off_low: 8'h96, off_misc: 8'h21, vsel: 8'h0f};
    @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    @(posedge i_sys_clk);
    rd_chk(8'h29, 8'h96);
    rd_chk(8'h2a, 8'h21);
    rd_chk(8'h2b, 8'h0f);
    $display("test reload done");
    end_sim();
  end
endmodule
